// ===== hw/rps_pkg.sv
/*
 * Shared types and constants for the ranging power and mode sequencer:
 * state and mode encodings, the host command carrier and the timing
 * figures converted to cycles of the 40 MHz reference clock.
 * Assumes every design file imports the whole package.
 */
package rps_pkg;

    // reference clock period
    localparam int CLK_PERIOD_NS = 25;

    // firmware boot, longest time, rounded down to whole cycles
    localparam int BOOT_TIME_NS = 1200000;
    localparam int BOOT_CYCLES_RAW = BOOT_TIME_NS / CLK_PERIOD_NS;
    localparam int BOOT_CYCLES = (BOOT_CYCLES_RAW < 1) ? 1 : BOOT_CYCLES_RAW;

    // default timing budget of one measurement
    localparam int MEAS_TIME_NS = 33000000;
    localparam int MEAS_CYCLES_RAW = MEAS_TIME_NS / CLK_PERIOD_NS;
    localparam int MEAS_CYCLES = (MEAS_CYCLES_RAW < 1) ? 1 : MEAS_CYCLES_RAW;

    // width of all duration counters
    localparam int CNT_WIDTH = 32;

    // firmware state seen by the host
    typedef enum logic [2:0] {
        ST_OFF,
        ST_HW_STBY,
        ST_BOOT,
        ST_SW_STBY,
        ST_MEAS,
        ST_WAIT
    } rps_state_type;

    // ranging mode chosen with the start command
    typedef enum logic [1:0] {
        MODE_SINGLE,
        MODE_CONT,
        MODE_TIMED
    } rps_mode_type;

    // host command strobes, one cycle each
    typedef struct packed {
        logic start;
        logic stop;
        rps_mode_type mode;
    } rps_cmd_type;

endpackage

// ===== hw/rps_sequencer.sv
/*
 * Power and ranging-mode sequencer of a time-of-flight sensor: power
 * off, hardware standby, boot, software standby and the three ranging
 * modes, with an open-drain result interrupt toward the host.
 * Assumes host inputs synchronous to ref_clk_i and one-cycle commands.
 */
module rps_sequencer
    import rps_pkg::*;
#(
    parameter int BOOT_LEN = BOOT_CYCLES,
    parameter int MEAS_LEN = MEAS_CYCLES
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // power and shutdown pins
    input wire logic main_supply_i,
    input wire logic shutdown_n_input_i,
    // host commands and settings
    input wire rps_cmd_type cmd_i,
    input wire logic [CNT_WIDTH-1:0] inter_meas_period_i,
    input wire logic irq_clear_i,
    // interrupt pin, open drain
    output logic result_interrupt_pin_o,
    output logic result_interrupt_pin_oe_o,
    // status
    output rps_state_type state_o,
    output logic result_valid_o,
    output logic bus_ready_o
);

    localparam logic [CNT_WIDTH-1:0] BOOT_CNT = CNT_WIDTH'(BOOT_LEN);
    localparam logic [CNT_WIDTH-1:0] MEAS_CNT = CNT_WIDTH'(MEAS_LEN);

    typedef struct packed {
        rps_state_type state;
        rps_mode_type mode;
        logic stop_pend;
        logic irq;
        logic pin_level;
        logic result_valid;
        logic bus_ready;
    } rps_seq_state_type;

    localparam rps_seq_state_type SEQ_RESET = '{
        state: ST_OFF,
        mode: MODE_SINGLE,
        default: 1'h0
    };

    rps_seq_state_type r;
    rps_seq_state_type next_r;
    logic tmr_load;
    logic tmr_abort;
    logic [CNT_WIDTH-1:0] tmr_count;
    logic tmr_done;

    // states in which the serial bus is deaf
    function automatic logic bus_off(input rps_state_type s);
        return (s == ST_OFF) || (s == ST_HW_STBY);
    endfunction

    // shared timer for boot, measurement and inter-measurement wait
    rps_timer #(
        .WIDTH(CNT_WIDTH)
    ) rps_timer_inst (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .load_i(tmr_load),
        .abort_i(tmr_abort),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // next state; supply and shutdown override every other event
    always_comb begin
        next_r = r;
        next_r.result_valid = 1'h0;
        next_r.pin_level = 1'h0;
        tmr_load = 1'h0;
        tmr_abort = 1'h0;
        tmr_count = MEAS_CNT;
        if (!main_supply_i) begin
            next_r.state = ST_OFF;
            tmr_abort = 1'h1;
        end else if (!shutdown_n_input_i) begin
            next_r.state = ST_HW_STBY;
            tmr_abort = 1'h1;
        end else begin
            case (r.state)
                ST_OFF, ST_HW_STBY: begin
                    next_r.state = ST_BOOT;
                    tmr_load = 1'h1;
                    tmr_count = BOOT_CNT;
                end
                ST_BOOT: begin
                    if (tmr_done) begin
                        next_r.state = ST_SW_STBY;
                    end
                end
                ST_SW_STBY: begin
                    if (cmd_i.start) begin
                        next_r.state = ST_MEAS;
                        next_r.mode = cmd_i.mode;
                        next_r.stop_pend = 1'h0;
                        tmr_load = 1'h1;
                    end
                end
                ST_MEAS: begin
                    if (cmd_i.stop) begin
                        next_r.stop_pend = 1'h1;
                    end
                    if (tmr_done) begin
                        next_r.result_valid = 1'h1;
                        next_r.irq = 1'h1;
                        if (r.mode == MODE_SINGLE || r.stop_pend
                            || cmd_i.stop) begin
                            next_r.state = ST_SW_STBY;
                            next_r.stop_pend = 1'h0;
                        end else if (r.mode == MODE_TIMED) begin
                            next_r.state = ST_WAIT;
                            tmr_load = 1'h1;
                            tmr_count = inter_meas_period_i;
                        end else begin
                            tmr_load = 1'h1;
                        end
                    end
                end
                ST_WAIT: begin
                    if (cmd_i.stop) begin
                        next_r.state = ST_SW_STBY;
                        tmr_abort = 1'h1;
                    end else if (tmr_done) begin
                        next_r.state = ST_MEAS;
                        tmr_load = 1'h1;
                    end
                end
                default: begin
                    next_r.state = ST_OFF;
                end
            endcase
        end
        // a clear in the result cycle loses to the new result
        if (irq_clear_i && !next_r.result_valid) begin
            next_r.irq = 1'h0;
        end
        // device logic is reset while unpowered or shut down
        if (bus_off(next_r.state)) begin
            next_r.irq = 1'h0;
        end
        next_r.bus_ready = !bus_off(next_r.state);
    end

    // state register, frozen while the enable is low
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r <= SEQ_RESET;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    // outputs straight from the register
    assign result_interrupt_pin_o = r.pin_level;
    assign result_interrupt_pin_oe_o = r.irq;
    assign state_o = r.state;
    assign result_valid_o = r.result_valid;
    assign bus_ready_o = r.bus_ready;

    // checks: powered, released and enabled
    logic live;
    assign live = clk_en_i && main_supply_i && shutdown_n_input_i;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_supply_off;
        clk_en_i && !main_supply_i |=> state_o == ST_OFF;
    endproperty
    a_supply_off: assert property (p_supply_off)
        else $error("supply loss did not power off");

    property p_shut_hold;
        clk_en_i && !shutdown_n_input_i |=> bus_off(state_o);
    endproperty
    a_shut_hold: assert property (p_shut_hold)
        else $error("device active while shutdown low");

    property p_hw_stby;
        clk_en_i && main_supply_i && !shutdown_n_input_i
            |=> state_o == ST_HW_STBY;
    endproperty
    a_hw_stby: assert property (p_hw_stby)
        else $error("shutdown low did not give hardware standby");

    property p_boot;
        live && state_o == ST_HW_STBY |=> state_o == ST_BOOT;
    endproperty
    a_boot: assert property (p_boot)
        else $error("shutdown release did not start boot");

    property p_boot_done;
        live && state_o == ST_BOOT && tmr_done |=> state_o == ST_SW_STBY;
    endproperty
    a_boot_done: assert property (p_boot_done)
        else $error("boot end did not reach software standby");

    property p_start;
        live && state_o == ST_SW_STBY && cmd_i.start
            |=> state_o == ST_MEAS && r.mode == $past(cmd_i.mode);
    endproperty
    a_start: assert property (p_start)
        else $error("start did not enter chosen mode");

    property p_single;
        live && state_o == ST_MEAS && r.mode == MODE_SINGLE && tmr_done
            |=> state_o == ST_SW_STBY;
    endproperty
    a_single: assert property (p_single)
        else $error("single mode did not return to standby");

    property p_cont;
        live && state_o == ST_MEAS && r.mode == MODE_CONT && tmr_done
            && !r.stop_pend && !cmd_i.stop |=> state_o == ST_MEAS;
    endproperty
    a_cont: assert property (p_cont)
        else $error("continuous mode left measuring");

    property p_stop_defer;
        live && state_o == ST_MEAS && cmd_i.stop && !tmr_done
            |=> state_o == ST_MEAS && r.stop_pend;
    endproperty
    a_stop_defer: assert property (p_stop_defer)
        else $error("stop aborted a measurement");

    property p_wait;
        live && state_o == ST_WAIT && !cmd_i.stop && !tmr_done
            |=> state_o == ST_WAIT;
    endproperty
    a_wait: assert property (p_wait)
        else $error("inter-measurement wait cut short");

    property p_wait_stop;
        live && state_o == ST_WAIT && cmd_i.stop |=> state_o == ST_SW_STBY;
    endproperty
    a_wait_stop: assert property (p_wait_stop)
        else $error("stop in wait not immediate");

    property p_irq;
        live && state_o == ST_MEAS && tmr_done
            |=> result_valid_o && result_interrupt_pin_oe_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("result gave no interrupt");

    property p_open_drain;
        !result_interrupt_pin_o;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("interrupt pin driven high");

    property p_bus;
        state_o == ST_HW_STBY |-> !bus_ready_o;
    endproperty
    a_bus: assert property (p_bus)
        else $error("bus ready in hardware standby");

endmodule

// ===== hw/rps_timer.sv
/*
 * Down-counting duration timer: a load starts it, done pulses for one
 * cycle when the loaded number of cycles has passed, abort stops it.
 * Assumes a synchronous active-low reset and a common clock enable.
 */
module rps_timer
    import rps_pkg::*;
#(
    parameter int WIDTH = CNT_WIDTH
) (
    // clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // control
    input wire logic load_i,
    input wire logic abort_i,
    input wire logic [WIDTH-1:0] count_i,
    // status
    output logic done_o
);

    localparam logic [WIDTH-1:0] TMR_ONE = {{(WIDTH-1){1'h0}}, 1'h1};

    typedef struct packed {
        logic [WIDTH-1:0] remain;
        logic running;
        logic done;
    } rps_tmr_state_type;

    localparam rps_tmr_state_type TMR_RESET = '0;

    rps_tmr_state_type r;
    rps_tmr_state_type next_r;

    // count down; a load in the done cycle restarts with no gap
    always_comb begin
        next_r = r;
        next_r.done = 1'h0;
        if (abort_i) begin
            next_r.running = 1'h0;
        end else if (load_i) begin
            // a zero count would wrap round to the top before finishing, so it behaves as one
            next_r.remain = (count_i == '0) ? TMR_ONE : count_i;
            next_r.running = 1'h1;
        end else if (r.running) begin
            if (r.remain == TMR_ONE) begin
                next_r.running = 1'h0;
                next_r.done = 1'h1;
            end else begin
                next_r.remain = r.remain - TMR_ONE;
            end
        end
    end

    // state register, frozen while the enable is low
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r <= TMR_RESET;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    assign done_o = r.done;

endmodule

// ===== verification/rps_host_model.sv
/*
 * Host-side model: drives the shutdown and supply pins from the bench's
 * requests and puts the pull-up on the open-drain interrupt line.
 * Assumes the bench sets its requests at time zero and on falling edges.
 */
module rps_host_model (
    // requests from the bench
    input wire logic shut_req_i,
    input wire logic supply_req_i,
    // interrupt pin from the device
    input wire logic pin_i,
    input wire logic pin_oe_i,
    // pins toward the device and the resolved line
    output logic shutdown_n_o,
    output logic main_supply_o,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    assign shutdown_n_o = shut_req_i;
    assign main_supply_o = supply_req_i;
    assign line_o = pin_oe_i ? pin_i : 1'h1;
endmodule

// ===== verification/rps_sequencer_test.sv
/*
 * Self-checking bench of the power and ranging-mode sequencer.
 * Assumes the host model beside it and short boot and measurement counts.
 */
module rps_sequencer_test
    import rps_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // short counts keep the run brief
    localparam int BOOT_N = 10;
    localparam int MEAS_N = 20;
    localparam int WAIT_N = 15;

    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic shut_req = 1'b0;
    logic supply_req = 1'b0;
    rps_cmd_type cmd_i = '0;
    logic [CNT_WIDTH-1:0] period = '0;
    logic irq_clear = 1'b0;
    logic shut_n, supply, pin, pin_oe, line, result_valid_o, bus_ready_o;
    rps_state_type state_o;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    rps_host_model rps_host_model_inst (.shut_req_i(shut_req),
        .supply_req_i(supply_req), .pin_i(pin), .pin_oe_i(pin_oe),
        .shutdown_n_o(shut_n), .main_supply_o(supply), .line_o(line));

    rps_sequencer #(.BOOT_LEN(BOOT_N), .MEAS_LEN(MEAS_N)) rps_sequencer_inst (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .main_supply_i(supply), .shutdown_n_input_i(shut_n),
        .cmd_i(cmd_i), .inter_meas_period_i(period),
        .irq_clear_i(irq_clear), .result_interrupt_pin_o(pin),
        .result_interrupt_pin_oe_o(pin_oe), .state_o(state_o),
        .result_valid_o(result_valid_o), .bus_ready_o(bus_ready_o));

    task automatic finish_test();
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_state(input rps_state_type exp);
        samples_checked++;
        if (state_o !== exp) begin
            errors++;
            $display("BAD t=%0t exp=%0h got=%0h", $time, exp, state_o);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t exp=%0h got=%0h", $time, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    // one-cycle command; returns after the edge that took it
    task automatic send(input logic go, input logic halt,
        input rps_mode_type m);
        cmd_i.start = go;
        cmd_i.stop = halt;
        cmd_i.mode = m;
        cyc(1);
        cmd_i.start = 1'b0;
        cmd_i.stop = 1'b0;
    endtask

    // bounded wait for the one-cycle result pulse
    task automatic wait_valid();
        int i;
        for (i = 0; i < MEAS_N + 4; i++) begin
            cyc(1);
            if (result_valid_o === 1'b1)
                break;
        end
        chk_bit(1'b1, result_valid_o); // result pulse seen
    endtask

    task automatic clear_irq();
        irq_clear = 1'b1;
        cyc(1);
        irq_clear = 1'b0;
        chk_bit(1'b1, line); // line released
    endtask

    task automatic t_power_up();
        chk_state(ST_OFF); // no supply yet
        supply_req = 1'b1;
        cyc(3);
        chk_state(ST_HW_STBY); // supply applied
        chk_bit(1'b0, bus_ready_o); // bus silent
        send(1'b1, 1'b0, MODE_SINGLE);
        chk_state(ST_HW_STBY); // held shut down
        shut_req = 1'b1;
        cyc(1);
        chk_state(ST_BOOT); // boot starts
        cyc(BOOT_N);
        chk_state(ST_BOOT); // boot not cut short
        cyc(1);
        chk_state(ST_SW_STBY); // standby alone
        chk_bit(1'h1, bus_ready_o); // bus answers once up
    endtask

    task automatic t_single();
        send(1'b1, 1'b0, MODE_SINGLE);
        chk_state(ST_MEAS); // start taken
        wait_valid(); // one result
        chk_state(ST_SW_STBY); // back to standby
        chk_bit(1'b0, line); // line pulled low
        clear_irq();
        cyc(MEAS_N + 2);
        chk_state(ST_SW_STBY); // no second run
    endtask

    task automatic t_cont();
        send(1'b1, 1'b0, MODE_CONT);
        wait_valid(); // result pulse
        chk_state(ST_MEAS); // no idle gap
        cyc(3);
        send(1'b0, 1'b1, MODE_CONT);
        chk_state(ST_MEAS); // not aborted
        wait_valid(); // measurement finished
        chk_state(ST_SW_STBY); // then standby
        clear_irq();
    endtask

    task automatic t_timed();
        period = WAIT_N;
        send(1'b1, 1'b0, MODE_TIMED);
        wait_valid(); // result pulse
        chk_state(ST_WAIT); // waits after result
        cyc(WAIT_N);
        chk_state(ST_WAIT); // full period
        cyc(1);
        chk_state(ST_MEAS); // restarts alone
        send(1'b0, 1'b1, MODE_TIMED);
        chk_state(ST_MEAS); // stop deferred
        wait_valid(); // measurement finished
        chk_state(ST_SW_STBY); // then standby
        send(1'b1, 1'b0, MODE_TIMED);
        wait_valid(); // first result
        cyc(2);
        send(1'b0, 1'b1, MODE_TIMED);
        chk_state(ST_SW_STBY); // stop at once in wait
    endtask

    // clock enable low freezes the countdown, it must not restart it
    task automatic t_freeze();
        send(1'h1, 1'h0, MODE_SINGLE);
        cyc(5);
        clk_en_i = 1'h0;
        cyc(10);
        chk_state(ST_MEAS); // held while frozen
        chk_bit(1'h0, result_valid_o); // no result while frozen
        clk_en_i = 1'h1;
        cyc(MEAS_N - 5);
        chk_bit(1'h0, result_valid_o); // countdown resumed late
        cyc(1);
        chk_bit(1'h1, result_valid_o); // result after resume
        chk_state(ST_SW_STBY); // single run over
    endtask

    // interrupt left pending on purpose, shutdown must drop it
    task automatic t_shutdown();
        send(1'b1, 1'b0, MODE_CONT);
        cyc(5);
        shut_req = 1'b0;
        cyc(1);
        chk_state(ST_HW_STBY); // activity abandoned
        chk_bit(1'b1, line); // pin released
        cyc(MEAS_N + 2);
        chk_state(ST_HW_STBY); // stays shut down
        chk_bit(1'b0, result_valid_o); // no late result
        shut_req = 1'b1;
        cyc(2);
        supply_req = 1'b0;
        cyc(1);
        chk_state(ST_OFF); // supply removed
        // shutdown tied high: straight to boot, no hardware standby
        supply_req = 1'h1;
        cyc(1);
        chk_state(ST_BOOT); // boot without standby
        cyc(BOOT_N + 1);
        chk_state(ST_SW_STBY); // standby alone
    endtask

    // ceiling far above the few hundred cycles the tests need
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            finish_test();
        end
    end

    initial begin
        repeat (12) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        cyc(1);
        t_power_up();
        t_single();
        t_cont();
        t_timed();
        t_freeze();
        t_shutdown();
        finish_test();
    end
endmodule
